// ---- hdl/clwf_defs.svh ----
// register offsets, field positions and reset values of the warning-flag block
`ifndef CLWF_DEFS_SVH
`define CLWF_DEFS_SVH
`define CLWF_ADR_CAP       4'h0
`define CLWF_ADR_E_SET     4'h1
`define CLWF_ADR_E_CLR     4'h2
`define CLWF_ADR_F_SET     4'h3
`define CLWF_ADR_F_CLR     4'h4
`define CLWF_ADR_CTRL      4'h5
`define CLWF_ADR_FLAGS     4'h6
`define CLWF_ADR_CSTAT     4'h7
`define CLWF_ADR_IRQ_STAT  4'h8
`define CLWF_ADR_IRQ_MASK  4'h9
`define CLWF_ADR_DETECT    4'ha
`define CLWF_FLG_EARLY     0
`define CLWF_FLG_FINAL     1
`define CLWF_FLG_SHORT     2
`define CLWF_FLG_TAB       3
`define CLWF_CTRL_LOAD     0
`define CLWF_CTRL_PAR2     1
`define CLWF_CAP_RST       16'h0000
`define CLWF_E_SET_RST     16'h0000
`define CLWF_E_CLR_RST     16'h0000
`define CLWF_F_SET_RST     16'hffff
`define CLWF_F_CLR_RST     16'h0000
`define CLWF_DISABLED_THR  16'hffff
`endif

// ---- hdl/clwf_pkg.sv ----
// types shared by the warning-flag block
package clwf_pkg;
   // one wishbone request
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [5:0]  adr;
      logic [31:0] dat;
   } clwf_wb_req_s;
   // load model select
   typedef enum logic {
      CLWF_LD_CURRENT = 1'b0,
      CLWF_LD_POWER   = 1'b1
   } clwf_load_e;
   // hysteresis state of one warning flag
   typedef enum logic [1:0] {
      CLWF_HY_IDLE = 2'b00,
      CLWF_HY_LOW  = 2'b01
   } clwf_hy_e;
endpackage : clwf_pkg

// ---- hdl/clwf_hyst.sv ----
// one hysteresis comparator for a capacity warning flag
`timescale 1ns/1ps
module clwf_hyst (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        upd,
   input  wire logic [15:0] cap,
   input  wire logic [15:0] set_thr,
   input  wire logic [15:0] clr_thr,
   input  wire logic        set_off,
   output logic             flag_q
);
   import clwf_pkg::*;
   clwf_hy_e st_q;   // state of the flag
   // set below set, clear above clear, hold between
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= CLWF_HY_IDLE;
      end else if (ce && upd) begin
         unique case (st_q)
            CLWF_HY_IDLE: begin
               if (!set_off && (cap < set_thr)) begin
                  st_q <= CLWF_HY_LOW;
               end
            end
            CLWF_HY_LOW: begin
               if (cap > clr_thr) begin
                  st_q <= CLWF_HY_IDLE;
               end
            end
            default: begin
               st_q <= CLWF_HY_IDLE;
            end
         endcase
      end
   end
   assign flag_q = (st_q == CLWF_HY_LOW);
endmodule : clwf_hyst

// ---- hdl/clwf_top.sv ----
// charge level warning flags with wishbone register slave
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`include "clwf_defs.svh"
module clwf_top (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  ce,
   input  wire clwf_pkg::clwf_wb_req_s wb_req,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic                  short_detect,
   input  wire logic                  tab_detect,
   output logic                       early_low_charge_flag,
   output logic                       final_low_charge_flag,
   output logic                       internal_short_flag,
   output logic                       tab_disconnect_flag,
   output logic                       load_model_bit,
   output logic                       irq
);
   import clwf_pkg::*;

   // reset, registers and flag state
   logic        rs1_q;                       // reset sync stage one
   logic        rst_n;                       // synchronised reset
   logic [15:0] cap_q;                       // remaining_capacity_value
   logic [15:0] e_set_q;                     // early_warn_set_threshold
   logic [15:0] e_clr_q;                     // early_warn_clear_threshold
   logic [15:0] f_set_q;                     // final_warn_set_threshold
   logic [15:0] f_clr_q;                     // final_warn_clear_threshold
   logic [1:0]  ctrl_q;                      // load mode, two-cell parallel
   logic        upd_q;                       // capacity updated pulse
   logic        short_q;                     // internal short latched
   logic        tab_q;                       // tab disconnect latched
   logic        e_flag;                      // early comparator output
   logic        f_flag;                      // final comparator output
   logic [3:0]  flags;                       // flags word
   logic [3:0]  flags_prev_q;                // flags last cycle
   logic [3:0]  ist_q;                       // sticky interrupt status
   logic [3:0]  imask_q;                     // interrupt mask
   logic        wr;                          // bus write accepted
   logic        rd;                          // bus access accepted
   logic [3:0]  idx;                         // word index
   logic [31:0] wdat;                        // raw write data, lanes merged by lane16
   logic        det_wr;                      // write-one to the detect word
   logic        ist_wr;                      // write-one to the status word
   logic [3:0]  rise;                        // flags that rose this cycle

   // reset release through two flops
   // asserts at once, releases on an edge so no flop leaves reset mid-cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rs1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_n <= rs1_q;
      end
   end

   // merge byte lanes of a write into a register value
   function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : lane16

   // low-lane write accepted at one word, shared by every write-one word
   function automatic logic wr_hit(input logic acc, input logic [3:0] at,
                                   input logic [3:0] want, input logic lane);
      return acc && (at == want) && lane;
   endfunction : wr_hit

   // bus decode
   assign idx  = wb_req.adr[5:2];
   assign rd   = wb_req.cyc && wb_req.stb && !wb_ack_o;
   assign wr   = rd && wb_req.we;
   assign wdat = wb_req.dat;
   assign det_wr = wr_hit(wr, idx, `CLWF_ADR_DETECT, wb_req.sel[0]);
   assign ist_wr = wr_hit(wr, idx, `CLWF_ADR_IRQ_STAT, wb_req.sel[0]);

   // writable registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_q   <= `CLWF_CAP_RST;
         e_set_q <= `CLWF_E_SET_RST;
         e_clr_q <= `CLWF_E_CLR_RST;
         f_set_q <= `CLWF_F_SET_RST;
         f_clr_q <= `CLWF_F_CLR_RST;
         ctrl_q  <= 2'h0;
         imask_q <= 4'h0;
         upd_q   <= 1'b0;
      end else if (ce) begin
         // update pulse lasts one enabled cycle
         upd_q <= 1'b0;
         if (wr) begin
            unique case (idx)
               `CLWF_ADR_CAP: begin
                  cap_q <= lane16(cap_q, wdat, wb_req.sel);
                  upd_q <= 1'b1;
               end
               `CLWF_ADR_E_SET: begin
                  e_set_q <= lane16(e_set_q, wdat, wb_req.sel);
               end
               `CLWF_ADR_E_CLR: begin
                  e_clr_q <= lane16(e_clr_q, wdat, wb_req.sel);
               end
               `CLWF_ADR_F_SET: begin
                  f_set_q <= lane16(f_set_q, wdat, wb_req.sel);
               end
               `CLWF_ADR_F_CLR: begin
                  f_clr_q <= lane16(f_clr_q, wdat, wb_req.sel);
               end
               `CLWF_ADR_CTRL: begin
                  if (wb_req.sel[0]) begin
                     ctrl_q <= wdat[1:0];
                  end
               end
               `CLWF_ADR_IRQ_MASK: begin
                  if (wb_req.sel[0]) begin
                     imask_q <= wdat[3:0];
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // early warning comparator
   clwf_hyst u_early (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .upd     (upd_q),
      .cap     (cap_q),
      .set_thr (e_set_q),
      .clr_thr (e_clr_q),
      .set_off (1'b0),
      .flag_q  (e_flag)
   );

   // final warning comparator, minus one disables setting
   // all ones is minus one: setting blocked, clearing still allowed
   clwf_hyst u_final (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .upd     (upd_q),
      .cap     (cap_q),
      .set_thr (f_set_q),
      .clr_thr (f_clr_q),
      .set_off (f_set_q == `CLWF_DISABLED_THR),
      .flag_q  (f_flag)
   );

   // detection flags latch on event, cleared by writing one to the detect word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         short_q <= 1'b0;
         tab_q   <= 1'b0;
      end else if (ce) begin
         // a detection in the clearing cycle wins, no event is lost
         if (short_detect) begin
            short_q <= 1'b1;
         end else if (det_wr && wdat[`CLWF_FLG_SHORT]) begin
            short_q <= 1'b0;
         end
         // tab events only count in two-cell parallel
         if (tab_detect && ctrl_q[`CLWF_CTRL_PAR2]) begin
            tab_q <= 1'b1;
         end else if (det_wr && wdat[`CLWF_FLG_TAB]) begin
            tab_q <= 1'b0;
         end
      end
   end

   assign flags = {tab_q, short_q, f_flag, e_flag};
   // rising edges feed the sticky status
   assign rise  = flags & ~flags_prev_q;

   // sticky interrupt status on rising flags, set beats clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ist_q        <= 4'h0;
         flags_prev_q <= 4'h0;
      end else if (ce) begin
         flags_prev_q <= flags;
         // write-one clears, a flag rising in the same edge sets again
         if (ist_wr) begin
            ist_q <= (ist_q & ~wdat[3:0]) | rise;
         end else begin
            ist_q <= ist_q | rise;
         end
      end
   end

   // read mux, ack and registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o              <= 1'b0;
         wb_dat_o              <= 32'h0;
         early_low_charge_flag <= 1'b0;
         final_low_charge_flag <= 1'b0;
         internal_short_flag   <= 1'b0;
         tab_disconnect_flag   <= 1'b0;
         load_model_bit        <= 1'b0;
         irq                   <= 1'b0;
      end else if (ce) begin
         // every request accepted with ce high is answered one edge later
         wb_ack_o              <= rd;
         // flag and load pins are registered copies, irq the registered masked status, one edge behind the state
         early_low_charge_flag <= e_flag;
         final_low_charge_flag <= f_flag;
         internal_short_flag   <= short_q;
         tab_disconnect_flag   <= tab_q;
         load_model_bit        <= ctrl_q[`CLWF_CTRL_LOAD];
         irq                   <= |(ist_q & imask_q);
         // read data only moves on a read, so it stands until the next one
         if (rd && !wb_req.we) begin
            unique case (idx)
               `CLWF_ADR_CAP:      wb_dat_o <= {16'h0, cap_q};
               `CLWF_ADR_E_SET:    wb_dat_o <= {16'h0, e_set_q};
               `CLWF_ADR_E_CLR:    wb_dat_o <= {16'h0, e_clr_q};
               `CLWF_ADR_F_SET:    wb_dat_o <= {16'h0, f_set_q};
               `CLWF_ADR_F_CLR:    wb_dat_o <= {16'h0, f_clr_q};
               `CLWF_ADR_CTRL:     wb_dat_o <= {30'h0, ctrl_q};
               `CLWF_ADR_FLAGS:    wb_dat_o <= {28'h0, flags};
               `CLWF_ADR_CSTAT:    wb_dat_o <= {31'h0, ctrl_q[`CLWF_CTRL_LOAD]};
               `CLWF_ADR_IRQ_STAT: wb_dat_o <= {28'h0, ist_q};
               `CLWF_ADR_IRQ_MASK: wb_dat_o <= {28'h0, imask_q};
               `CLWF_ADR_DETECT:   wb_dat_o <= {28'h0, flags};
               default:            wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // assertions
   // an accepted request on the bus
   sequence s_bus_take;
      ce && wb_req.cyc && wb_req.stb && !wb_ack_o;
   endsequence
   // a short event taken, next edge enabled as well
   sequence s_short_taken;
      ce && short_detect ##1 ce;
   endsequence
   // short event held in its latch, then shown on the pin
   sequence s_short_seen;
      short_q ##1 internal_short_flag;
   endsequence
   // a tab event taken in two-cell parallel, next edge enabled
   sequence s_tab_taken;
      ce && tab_detect && ctrl_q[`CLWF_CTRL_PAR2] ##1 ce;
   endsequence
   // tab event held in its latch, then shown on the pin
   sequence s_tab_seen;
      tab_q ##1 tab_disconnect_flag;
   endsequence

   a_early_set: assert property (@(posedge clk) disable iff (!rst_n)
      ce && upd_q && !e_flag && cap_q < e_set_q |=> e_flag)
      else $error("early flag not set below threshold");

   a_early_clr: assert property (@(posedge clk) disable iff (!rst_n)
      ce && upd_q && e_flag && cap_q > e_clr_q |=> !e_flag)
      else $error("early flag not cleared above threshold");

   a_final_set: assert property (@(posedge clk) disable iff (!rst_n)
      ce && upd_q && !f_flag && cap_q < f_set_q && f_set_q != `CLWF_DISABLED_THR |=> f_flag)
      else $error("final flag not set below threshold");

   a_final_off: assert property (@(posedge clk) disable iff (!rst_n)
      !f_flag && f_set_q == `CLWF_DISABLED_THR |=> !f_flag)
      else $error("final flag set while disabled");

   a_final_clr: assert property (@(posedge clk) disable iff (!rst_n)
      ce && upd_q && f_flag && cap_q > f_clr_q |=> !f_flag)
      else $error("final flag not cleared");

   a_short_set: assert property (@(posedge clk) disable iff (!rst_n)
      s_short_taken |-> s_short_seen)
      else $error("short flag missing");

   a_tab_set: assert property (@(posedge clk) disable iff (!rst_n)
      s_tab_taken |-> s_tab_seen)
      else $error("tab flag missing");

   a_tab_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl_q[`CLWF_CTRL_PAR2] && !tab_q |=> !tab_q)
      else $error("tab flag set outside two-cell parallel");

   a_load_mirror: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> load_model_bit == $past(ctrl_q[`CLWF_CTRL_LOAD]))
      else $error("load model not mirrored");

   a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !upd_q |=> $stable(e_flag) && $stable(f_flag))
      else $error("flag moved without update");

   a_early_pin: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> early_low_charge_flag == $past(e_flag))
      else $error("early pin does not follow its flag");

   a_final_pin: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> final_low_charge_flag == $past(f_flag))
      else $error("final pin does not follow its flag");

   a_read_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      rd && !wb_req.we && !short_detect && !tab_detect |=> $stable(short_q) && $stable(tab_q))
      else $error("read changed a detection flag");

   a_ack_answer: assert property (@(posedge clk) disable iff (!rst_n)
      s_bus_take |=> wb_ack_o)
      else $error("request not acknowledged");

   a_ack_drop: assert property (@(posedge clk) disable iff (!rst_n)
      ce && wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_status_set: assert property (@(posedge clk) disable iff (!rst_n)
      ce && (|rise) |=> (ist_q & $past(rise)) == $past(rise))
      else $error("rising flag missing from status");

   a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      ce && imask_q == 4'h0 |=> !irq)
      else $error("interrupt raised while fully masked");
endmodule : clwf_top

// ---- tb/clwf_tb.sv ----
// self-checking bench of the charge level warning flags block
`timescale 1ns/1ps
`include "clwf_defs.svh"
module tb;
   import clwf_pkg::*;
   // one noted read result
   typedef struct packed {
      logic [31:0] data;                        // expected read data
      logic [5:0]  pins;                        // {irq, load, tab, short, final, early}
      logic        chk;                         // pins compared as well
   } clwf_exp_s;
   logic         clk          = 1'b0;
   logic         rstn         = 1'b0;
   logic         ce           = 1'b1;           // clock enable
   clwf_wb_req_s wb_req       = '0;
   logic [31:0]  wb_dat_o;
   logic         wb_ack_o;
   logic         short_detect = 1'b0;
   logic         tab_detect   = 1'b0;
   wire  [5:0]   pins;                          // observed flag, load and irq pins
   logic         ldm          = 1'b0;           // expected load model pin
   logic [31:0]  rnd          = 32'h1568adac;   // xorshift state
   int           err_count    = 0;
   int           samples_checked = 0;
   clwf_exp_s    exp_q[$];                      // notes awaiting an answer
   clwf_exp_s    e;
   // capacity steps: base, random span, expected {final, early}
   logic [15:0]  base [8] = '{16'h0000, 16'h0000, 16'h0032, 16'h003d,
                              16'h0064, 16'h00c9, 16'h0064, 16'h0063};
   logic [15:0]  span [8] = '{16'h0001, 16'h0001, 16'h000b, 16'h0001,
                              16'h0065, 16'h0001, 16'h0065, 16'h0001};
   logic [1:0]   fexp [8] = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1};

   always #25 clk = ~clk;

   clwf_top clwf_top_inst (
      .clk                   (clk),
      .rstn                  (rstn),
      .ce                    (ce),
      .wb_req                (wb_req),
      .wb_dat_o              (wb_dat_o),
      .wb_ack_o              (wb_ack_o),
      .short_detect          (short_detect),
      .tab_detect            (tab_detect),
      .early_low_charge_flag (pins[0]),
      .final_low_charge_flag (pins[1]),
      .internal_short_flag   (pins[2]),
      .tab_disconnect_flag   (pins[3]),
      .load_model_bit        (pins[4]),
      .irq                   (pins[5])
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // one classic cycle; upper data lanes random, they must be ignored
   task automatic bus(input logic we, input logic [3:0] idx, input logic [15:0] v,
                      input clwf_exp_s ex);
      int n;
      rnd = xs(rnd);
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: {idx, 2'b00},
                  dat: {rnd[31:16], v}};
      if (!we) exp_q.push_back(ex);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      wb_req <= '0;
      if (n >= 50) begin
         err_count++;
         tally_and_finish();
      end
   endtask : bus

   task automatic wr(input logic [3:0] idx, input logic [15:0] v);
      bus(1'b1, idx, v, '0);
   endtask : wr

   task automatic rd(input logic [3:0] idx, input logic [31:0] want);
      bus(1'b0, idx, 16'h0000, '{data: want, pins: 6'h00, chk: 1'b0});
   endtask : rd

   // flags word read, with the pins compared at the answer
   task automatic rdf(input logic [3:0] f, input logic irq_x);
      bus(1'b0, `CLWF_ADR_FLAGS, 16'h0000,
          '{data: {28'h0, f}, pins: {irq_x, ldm, f}, chk: 1'b1});
   endtask : rdf

   // one-cycle detection event, then let it settle
   task automatic pulse(input logic tab);
      @(posedge clk);
      if (tab) tab_detect <= 1'b1;
      else short_detect <= 1'b1;
      @(posedge clk);
      tab_detect <= 1'b0;
      short_detect <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse

   // answer watcher: takes the oldest note at each read acknowledge
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1 && wb_req.we === 1'b0) begin
         if (exp_q.size() == 0) begin
            err_count++;
         end else begin
            e = exp_q.pop_front();
            check(wb_dat_o, e.data);
            if (e.chk) check({26'h0, pins}, {26'h0, e.pins});
         end
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(`CLWF_ADR_F_SET, 32'h0000ffff);
      rd(`CLWF_ADR_CSTAT, 32'h00000000);
      rdf(4'h0, 1'b0);
      // both load models, mirrored in status and pin
      for (int m = 0; m < 2; m++) begin
         wr(`CLWF_ADR_CTRL, {15'h0000, m[0]});
         ldm = m[0];
         rd(`CLWF_ADR_CSTAT, {31'h0, ldm});
         rdf(4'h0, 1'b0);
      end
      // hysteresis walk, final set starts disabled
      wr(`CLWF_ADR_E_SET, 16'h0064);
      wr(`CLWF_ADR_E_CLR, 16'h00c8);
      wr(`CLWF_ADR_F_CLR, 16'h003c);
      for (int i = 0; i < 8; i++) begin
         if (i == 1) wr(`CLWF_ADR_F_SET, 16'h0032);
         rnd = xs(rnd);
         wr(`CLWF_ADR_CAP, base[i] + rnd[15:0] % span[i]);
         repeat (4) @(posedge clk);
         rdf({2'b00, fexp[i]}, 1'b0);
      end
      // events, status, mask and clearing
      rd(`CLWF_ADR_IRQ_STAT, 32'h00000003);
      wr(`CLWF_ADR_IRQ_STAT, 16'h000f);
      rd(`CLWF_ADR_IRQ_STAT, 32'h00000000);
      pulse(1'b0);
      rdf(4'h5, 1'b0);
      wr(`CLWF_ADR_IRQ_MASK, 16'h0004);
      rdf(4'h5, 1'b1);
      wr(`CLWF_ADR_IRQ_STAT, 16'h0004);
      rdf(4'h5, 1'b0);
      rd(`CLWF_ADR_DETECT, 32'h00000005);
      wr(`CLWF_ADR_DETECT, 16'h0004);
      rdf(4'h1, 1'b0);
      // enable low freezes state: a short event then is not taken
      @(posedge clk);
      ce <= 1'b0;
      short_detect <= 1'b1;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      short_detect <= 1'b0;
      rdf(4'h1, 1'b0);
      // tab event ignored until two-cell parallel is on
      pulse(1'b1);
      rdf(4'h1, 1'b0);
      wr(`CLWF_ADR_CTRL, 16'h0003);
      pulse(1'b1);
      rdf(4'h9, 1'b0);
      rd(`CLWF_ADR_IRQ_STAT, 32'h00000008);
      rd(4'hf, 32'h00000000);
      rdf(4'h9, 1'b0);
      tally_and_finish();
   end
endmodule : tb
